// *** hw/dpsc_defs.svh ***
// constants for the dual pot serial command block
`ifndef DPSC_DEFS_SVH
`define DPSC_DEFS_SVH
// device type code: the value is arbitrary, set it to the real part's code
`define DPSC_DEV_TYPE        4'hc
`define DPSC_OP_RD_WIPER     4'h9
`define DPSC_OP_WR_WIPER     4'ha
`define DPSC_OP_RD_SLOT      4'hb
`define DPSC_OP_WR_SLOT      4'hc
`define DPSC_OP_SLOT_TO_WP   4'hd
`define DPSC_OP_WP_TO_SLOT   4'he
`define DPSC_OP_G_SLOT_TO_WP 4'h1
`define DPSC_OP_G_WP_TO_SLOT 4'h8
`define DPSC_OP_INCDEC       4'h2
`define DPSC_OP_STATUS       4'h5
`define DPSC_CLK_MHZ         100
`define DPSC_NV_WRITE_MS     5
`define DPSC_NV_WRITE_CYC    (`DPSC_NV_WRITE_MS * 1000 * `DPSC_CLK_MHZ)
`define DPSC_SETTLE_MIN_US   5
`define DPSC_SETTLE_MIN_CYC  (`DPSC_SETTLE_MIN_US * `DPSC_CLK_MHZ)
`define DPSC_SETTLE_MAX_US   10
`define DPSC_SETTLE_MAX_CYC  (`DPSC_SETTLE_MAX_US * `DPSC_CLK_MHZ)
`define DPSC_SLOT_RESET      8'h80
`endif

// *** hw/dpsc_pkg.sv ***
// types for the dual pot serial command block
`default_nettype none
package dpsc_pkg;
    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic       sdi;
    } dpsc_link_t;
    typedef struct packed {
        logic [7:0] pos0;
        logic [7:0] pos1;
    } dpsc_taps_t;
endpackage
`default_nettype wire

// *** hw/dpsc_tap_settle.sv ***
// delays a wiper register value onto the tap decoder
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_defs.svh"
module dpsc_tap_settle (
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    input  wire logic [7:0]   i_position,
    output logic      [7:0]   o_position,
    output logic      [255:0] o_tap_onehot
);
    localparam int unsigned DELAY = `DPSC_SETTLE_MIN_CYC + 50;
    logic [7:0]  pend_reg;
    logic [15:0] cnt_reg;
    // a change restarts the wait, so the tap moves between 5 and 10 us after it
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pend_reg <= 8'h00;
            cnt_reg  <= 16'h0000;
        end else if (i_position != pend_reg) begin
            pend_reg <= i_position;
            cnt_reg  <= 16'(DELAY);
        end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_position <= 8'h00;
        end else if (cnt_reg == 16'h0001) begin
            o_position <= pend_reg;
        end
    end
    genvar g;
    generate
        for (g = 0; g < 256; g++) begin : g_tap
            assign o_tap_onehot[g] = (o_position == 8'(g));
        end
    endgenerate
    settle_window_a : assert property (@(posedge i_clock) disable iff (i_rst)
        $changed(pend_reg) |-> ##[500:1000] (o_position == pend_reg))
        else $error("tap did not settle in window");
endmodule
`default_nettype wire

// *** hw/dpsc_core.sv ***
// serial command decoder and register set of a dual digital potentiometer
//
// Function
// - address byte first; upper four bits are checked against the device type
// - low two address bits must equal board select pins, else abandon
// - second byte: top four bits opcode, lowest bit pot select
// - slot select bits pick one of four slots; 00 slot zero, 01 slot one
// - each pot has 8-bit wiper register decoded to one of 256 taps
// - wiper changes only by write, slot transfer, step, or power-up load
// - at power-up each wiper loads from its slot zero
// - wiper registers are volatile; after power-up they hold slot zero
// - four 8-bit nonvolatile slots per pot, readable, writable, exchangeable
// - a slot change completes within 5 ms
// - nonvolatile save starts when chip select rises after a full write
// - write-busy flag reported through the read-status command
// - wiper tap moves 5 to 10 us after a wiper-changing instruction
// - after power stable tap reaches power-up position in 5 to 10 us
// - after step command each clock pulse moves wiper up if data high, else down
// - write-busy flag reads 1 during nonvolatile write, 0 otherwise
// - ten instructions; five are three bytes long
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_defs.svh"
module dpsc_core #(
    parameter int unsigned NV_WRITE_CYC = `DPSC_NV_WRITE_CYC
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_rst,
    input  wire dpsc_pkg::dpsc_link_t i_link,
    input  wire logic [1:0]           i_board_select_pins,
    output logic                      o_sdo,
    output logic                      o_sdo_oe_n,
    output dpsc_pkg::dpsc_taps_t      o_taps,
    output logic [255:0]              o_tap0_onehot,
    output logic [255:0]              o_tap1_onehot,
    output logic                      o_write_busy_flag
);
    import dpsc_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [1:0] bsel_meta_reg;
    logic [1:0] bsel_reg;
    logic       sck_d_reg;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            // idle levels: deselected, clock low, so no false edge follows reset
            meta_reg      <= 3'h4;
            sync_reg      <= 3'h4;
            bsel_meta_reg <= 2'h0;
            bsel_reg      <= 2'h0;
            sck_d_reg     <= 1'b0;
        end else begin
            meta_reg      <= {i_link.cs_n, i_link.sck, i_link.sdi};
            sync_reg      <= meta_reg;
            bsel_meta_reg <= i_board_select_pins;
            bsel_reg      <= bsel_meta_reg;
            sck_d_reg     <= sync_reg[1];
        end
    end
    logic cs_n;
    logic sdi;
    logic sck_rise;
    logic sck_fall;
    assign cs_n     = sync_reg[2];
    assign sdi      = sync_reg[0];
    assign sck_rise = ~cs_n & sync_reg[1] & ~sck_d_reg;
    assign sck_fall = ~cs_n & ~sync_reg[1] & sck_d_reg;

    // ****************************************
    // storage
    // ****************************************
    logic [7:0] slot_mem [0:1][0:3];
    logic [7:0] wiper_position_reg [0:1];
    logic       nv_busy_reg;

    // ****************************************
    // command sequencer
    // ****************************************
    typedef enum {ST_ADDR, ST_INSTR, ST_DATA, ST_STEP, ST_IGNORE, ST_DONE} dpsc_state_t;
    dpsc_state_t state_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  bit_reg;
    logic [3:0]  op_reg;
    logic [1:0]  slot_reg;
    logic        pot_reg;
    logic        wr_pending_reg;
    logic        byte_done;
    logic [7:0]  byte_in;
    assign byte_done = sck_rise && (bit_reg == 3'h7);
    assign byte_in   = {shift_reg[6:0], sdi};

    always_ff @(posedge i_clock) begin
        if (i_rst || cs_n) begin
            bit_reg   <= 3'h0;
            shift_reg <= 8'h00;
        end else if (sck_rise) begin
            bit_reg   <= bit_reg + 3'h1;
            shift_reg <= byte_in;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || cs_n) begin
            state_reg <= ST_ADDR;
        end else if (sck_rise) begin
            case (state_reg)
                ST_ADDR: begin
                    if (byte_done) begin
                        if (byte_in[7:4] == `DPSC_DEV_TYPE && byte_in[1:0] == bsel_reg) begin
                            state_reg <= ST_INSTR;
                        end else begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_INSTR: begin
                    if (byte_done) begin
                        case (byte_in[7:4])
                            `DPSC_OP_RD_WIPER, `DPSC_OP_WR_WIPER, `DPSC_OP_RD_SLOT,
                            `DPSC_OP_WR_SLOT, `DPSC_OP_STATUS: state_reg <= ST_DATA;
                            `DPSC_OP_INCDEC: state_reg <= ST_STEP;
                            default: state_reg <= ST_DONE;
                        endcase
                    end
                end
                ST_DATA: begin
                    if (byte_done) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_STEP:   state_reg <= ST_STEP;
                ST_IGNORE: state_reg <= ST_IGNORE;
                default:   state_reg <= ST_DONE;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            op_reg   <= 4'h0;
            slot_reg <= 2'h0;
            pot_reg  <= 1'b0;
        end else if (state_reg == ST_INSTR && byte_done) begin
            op_reg   <= byte_in[7:4];
            slot_reg <= byte_in[3:2];
            pot_reg  <= byte_in[0];
        end
    end

    // ****************************************
    // command execution
    // ****************************************
    logic exec_two;
    logic exec_data;
    logic step_evt;
    assign exec_two  = (state_reg == ST_INSTR) && byte_done;
    assign exec_data = (state_reg == ST_DATA) && byte_done;
    assign step_evt  = (state_reg == ST_STEP) && sck_rise;

    // power-up load is modelled by reset: slots hold their reset image
    logic boot_reg;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            boot_reg <= 1'b1;
        end else begin
            boot_reg <= 1'b0;
        end
    end

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pot
            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    wiper_position_reg[p] <= 8'h00;
                end else if (boot_reg) begin
                    wiper_position_reg[p] <= slot_mem[p][0];
                end else if (exec_two && byte_in[7:4] == `DPSC_OP_SLOT_TO_WP && byte_in[0] == 1'(p)) begin
                    wiper_position_reg[p] <= slot_mem[p][byte_in[3:2]];
                end else if (exec_two && byte_in[7:4] == `DPSC_OP_G_SLOT_TO_WP) begin
                    wiper_position_reg[p] <= slot_mem[p][byte_in[3:2]];
                end else if (exec_data && op_reg == `DPSC_OP_WR_WIPER && pot_reg == 1'(p)) begin
                    wiper_position_reg[p] <= byte_in;
                end else if (step_evt && pot_reg == 1'(p)) begin
                    if (sdi && wiper_position_reg[p] != 8'hff) begin
                        wiper_position_reg[p] <= wiper_position_reg[p] + 8'h01;
                    end else if (!sdi && wiper_position_reg[p] != 8'h00) begin
                        wiper_position_reg[p] <= wiper_position_reg[p] - 8'h01;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // nonvolatile write: staged, committed after chip select rises
    // ****************************************
    logic [7:0] stage_val [0:1];
    logic [1:0] stage_en_reg;
    logic [7:0] stage_reg [0:1];
    logic [1:0] stage_slot_reg;
    logic [31:0] nv_cnt_reg;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            stage_en_reg   <= 2'h0;
            stage_slot_reg <= 2'h0;
            stage_reg[0]   <= 8'h00;
            stage_reg[1]   <= 8'h00;
            wr_pending_reg <= 1'b0;
        end else if (cs_n) begin
            wr_pending_reg <= 1'b0;
            // keep the staged write until its save cycle has finished
            stage_en_reg   <= (wr_pending_reg || nv_busy_reg) ? stage_en_reg : 2'h0;
        end else if (!nv_busy_reg && exec_data && op_reg == `DPSC_OP_WR_SLOT) begin
            stage_en_reg   <= pot_reg ? 2'h2 : 2'h1;
            stage_slot_reg <= slot_reg;
            stage_reg[pot_reg] <= byte_in;
            wr_pending_reg <= 1'b1;
        end else if (!nv_busy_reg && exec_two && byte_in[7:4] == `DPSC_OP_WP_TO_SLOT) begin
            stage_en_reg   <= byte_in[0] ? 2'h2 : 2'h1;
            stage_slot_reg <= byte_in[3:2];
            stage_reg[0]   <= wiper_position_reg[0];
            stage_reg[1]   <= wiper_position_reg[1];
            wr_pending_reg <= 1'b1;
        end else if (!nv_busy_reg && exec_two && byte_in[7:4] == `DPSC_OP_G_WP_TO_SLOT) begin
            stage_en_reg   <= 2'h3;
            stage_slot_reg <= byte_in[3:2];
            stage_reg[0]   <= wiper_position_reg[0];
            stage_reg[1]   <= wiper_position_reg[1];
            wr_pending_reg <= 1'b1;
        end
    end
    assign stage_val[0] = stage_reg[0];
    assign stage_val[1] = stage_reg[1];

    logic nv_start;
    assign nv_start = cs_n && wr_pending_reg && !nv_busy_reg;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            nv_busy_reg <= 1'b0;
            nv_cnt_reg  <= 32'h0;
        end else if (nv_start) begin
            nv_busy_reg <= 1'b1;
            nv_cnt_reg  <= NV_WRITE_CYC - 1;
        end else if (nv_busy_reg) begin
            if (nv_cnt_reg == 32'h0) begin
                nv_busy_reg <= 1'b0;
            end else begin
                nv_cnt_reg <= nv_cnt_reg - 32'h1;
            end
        end
    end

    // slots commit at the end of the write cycle
    generate
        for (p = 0; p < 2; p++) begin : g_slot
            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    for (int s = 0; s < 4; s++) begin
                        slot_mem[p][s] <= `DPSC_SLOT_RESET;
                    end
                end else if (nv_busy_reg && nv_cnt_reg == 32'h0 && stage_en_reg[p]) begin
                    slot_mem[p][stage_slot_reg] <= stage_val[p];
                end
            end
        end
    endgenerate

    // ****************************************
    // serial read data
    // ****************************************
    logic [7:0] out_reg;
    logic       out_en_reg;
    always_ff @(posedge i_clock) begin
        if (i_rst || cs_n) begin
            out_reg    <= 8'h00;
            out_en_reg <= 1'b0;
        end else if (exec_two && byte_in[7:4] == `DPSC_OP_RD_WIPER) begin
            out_reg    <= wiper_position_reg[byte_in[0]];
            out_en_reg <= 1'b1;
        end else if (exec_two && byte_in[7:4] == `DPSC_OP_RD_SLOT) begin
            out_reg    <= slot_mem[byte_in[0]][byte_in[3:2]];
            out_en_reg <= 1'b1;
        end else if (exec_two && byte_in[7:4] == `DPSC_OP_STATUS) begin
            out_reg    <= {7'h00, nv_busy_reg};
            out_en_reg <= 1'b1;
        end else if (state_reg == ST_DATA && sck_fall && bit_reg != 3'h0) begin
            out_reg <= {out_reg[6:0], 1'b0};
        end else if (state_reg == ST_DONE) begin
            out_en_reg <= 1'b0;
        end
    end
    assign o_sdo             = out_reg[7];
    assign o_sdo_oe_n        = ~out_en_reg;
    assign o_write_busy_flag = nv_busy_reg;

    dpsc_tap_settle u_tap0 (
        .i_clock      (i_clock),
        .i_rst        (i_rst),
        .i_position   (wiper_position_reg[0]),
        .o_position   (o_taps.pos0),
        .o_tap_onehot (o_tap0_onehot)
    );
    dpsc_tap_settle u_tap1 (
        .i_clock      (i_clock),
        .i_rst        (i_rst),
        .i_position   (wiper_position_reg[1]),
        .o_position   (o_taps.pos1),
        .o_tap_onehot (o_tap1_onehot)
    );

    // ****************************************
    // checks
    // ****************************************
    mismatch_quiet_a : assert property (@(posedge i_clock) disable iff (i_rst)
        (state_reg == ST_IGNORE) |-> o_sdo_oe_n)
        else $error("output driven after address mismatch");
    save_on_cs_a : assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(nv_busy_reg) |-> $past(cs_n))
        else $error("save started while selected");
    busy_len_a : assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(nv_busy_reg) |-> nv_cnt_reg == NV_WRITE_CYC - 1)
        else $error("write time wrong");
    boot_load_a : assert property (@(posedge i_clock) disable iff (i_rst)
        $fell(boot_reg) |-> wiper_position_reg[0] == slot_mem[0][0])
        else $error("wiper not loaded from slot zero");
    addr_check_a : assert property (@(posedge i_clock) disable iff (i_rst)
        (state_reg == ST_ADDR && byte_done && byte_in[1:0] != bsel_reg) |=> state_reg != ST_INSTR)
        else $error("mismatched address accepted");
    status_bit_a : assert property (@(posedge i_clock) disable iff (i_rst)
        (exec_two && byte_in[7:4] == `DPSC_OP_STATUS) |=> out_reg == {7'h00, $past(nv_busy_reg)})
        else $error("status flag wrong");
    step_up_a : assert property (@(posedge i_clock) disable iff (i_rst)
        (step_evt && sdi && !pot_reg && wiper_position_reg[0] != 8'hff && !boot_reg)
            |=> wiper_position_reg[0] == $past(wiper_position_reg[0]) + 8'h01)
        else $error("step up missed");
    opcode_cap_a : assert property (@(posedge i_clock) disable iff (i_rst)
        exec_two |=> op_reg == $past(byte_in[7:4]))
        else $error("opcode not captured");
endmodule
`default_nettype wire

// *** tb/dpsc_host_model.sv ***
// behavioural serial host that drives the pot block link
`timescale 1ns/1ps
`default_nettype none
module dpsc_host_model (
    input  wire logic           i_clock,
    input  wire logic           i_sdo,
    input  wire logic           i_sdo_oe_n,
    output var dpsc_pkg::dpsc_link_t o_link
);
    import dpsc_pkg::*;
    logic drove;

    initial begin
        o_link = '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
        drove = 1'b0;
    end

    // notes whether the block ever drove its data line in this frame
    always @(posedge i_clock) begin
        if (!o_link.cs_n && i_sdo_oe_n === 1'b0) begin
            drove <= 1'b1;
        end
    end

    // ****************************************
    // one framed transfer, msb first, sck idles low
    // ****************************************
    task automatic frame(input int nbits, input logic [23:0] tx, output logic [7:0] rx, output logic seen);
        int i;
        rx = 8'h00;
        repeat (4) @(posedge i_clock);
        #1;
        drove = 1'b0;
        o_link.cs_n = 1'b0;
        repeat (25) @(posedge i_clock);
        for (i = 0; i < nbits; i++) begin
            @(posedge i_clock);
            #1;
            o_link.sck = 1'b0;
            o_link.sdi = tx[23 - i];
            repeat (7) @(posedge i_clock);
            #1;
            // a released line reads as the inverse of the last bit, never as a lucky match
            if (i >= 16) rx = {rx[6:0], (i_sdo_oe_n === 1'b0) ? i_sdo : ~rx[0]};
            o_link.sck = 1'b1;
            repeat (7) @(posedge i_clock);
        end
        @(posedge i_clock);
        #1;
        o_link.sck = 1'b0;
        repeat (25) @(posedge i_clock);
        #1;
        o_link.cs_n = 1'b1;
        o_link.sdi = ~o_link.sdi;
        seen = drove;
    endtask
endmodule
`default_nettype wire

// *** tb/test_dual_pot_serial_command_regs.sv ***
// self-checking bench for the dual pot serial command block
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_defs.svh"
module test_dual_pot_serial_command_regs;
    import dpsc_pkg::*;
    // long enough that a status read fits inside one nonvolatile write
    localparam int NV_CYC = 1000;
    logic         i_clock;
    logic         i_rst;
    logic [1:0]   board;
    dpsc_link_t   link;
    logic         sdo;
    logic         sdo_oe_n;
    dpsc_taps_t   taps;
    logic [255:0] hot0;
    logic [255:0] hot1;
    logic         busy;
    int           error_cnt = 0;
    int           checked = 0;
    int           cyc = 0;
    int           p;
    int           s;
    logic [31:0]  rnd = 32'h49fe;
    logic [7:0]   wp [2];
    logic [7:0]   sl [2][4];
    logic [7:0]   rx;
    logic [7:0]   v;
    logic         seen;

    dpsc_core #(.NV_WRITE_CYC(NV_CYC)) dpsc_core_inst (.i_clock(i_clock), .i_rst(i_rst), .i_link(link),
        .i_board_select_pins(board), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_taps(taps),
        .o_tap0_onehot(hot0), .o_tap1_onehot(hot1), .o_write_busy_flag(busy));
    dpsc_host_model dpsc_host_model_inst (.i_clock(i_clock), .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n), .o_link(link));

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) cyc <= cyc + 1;

    // ****************************************
    // helpers
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic roll();
        rnd = lfsr(rnd);
        v = rnd[7:0];
    endtask
    task automatic check(input string what, input logic [255:0] got, input logic [255:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic raw(input logic [7:0] a, input int n, input logic [3:0] op, input logic [1:0] sel,
                       input logic pot, input logic [7:0] d);
        dpsc_host_model_inst.frame(n, {a, op, sel, 1'b0, pot, d}, rx, seen);
    endtask
    task automatic cmd(input int n, input logic [3:0] op, input logic [1:0] sel, input logic pot,
                       input logic [7:0] d);
        raw({`DPSC_DEV_TYPE, 2'b00, board}, n, op, sel, pot, d);
    endtask
    task automatic read_all();
        int q;
        int r;
        for (q = 0; q < 2; q++) begin
            cmd(24, `DPSC_OP_RD_WIPER, 2'b00, q[0], 8'h00);
            check("wiper read", rx, wp[q]);
            for (r = 0; r < 4; r++) begin
                cmd(24, `DPSC_OP_RD_SLOT, r[1:0], q[0], 8'h00);
                check("slot read", rx, sl[q][r]);
            end
        end
    endtask
    task automatic wait_nv();
        int t0;
        int n;
        check("busy before cs rise", busy, 1'b0);
        for (n = 0; n < 10 && busy !== 1'b1; n++) tick(1);
        check("busy start", busy, 1'b1);
        t0 = cyc;
        cmd(24, `DPSC_OP_STATUS, 2'b00, 1'b1, 8'h00);
        check("status while busy", rx[0], 1'b1);
        for (n = 0; n < NV_CYC + 50 && busy !== 1'b0; n++) tick(1);
        check("write length", (cyc - t0 >= NV_CYC - 2) && (cyc - t0 <= NV_CYC + 10), 1'b1);
        cmd(24, `DPSC_OP_STATUS, 2'b00, 1'b1, 8'h00);
        check("status idle", rx[0], 1'b0);
    endtask
    task automatic powerup();
        int q;
        int r;
        for (q = 0; q < 2; q++) begin
            for (r = 0; r < 4; r++) sl[q][r] = `DPSC_SLOT_RESET;
            wp[q] = sl[q][0];
        end
        tick(400);
        check("early taps", taps, 16'h0000);
        tick(200);
        check("tap0 load", taps.pos0, wp[0]);
        check("tap1 load", taps.pos1, wp[1]);
        check("onehot0", hot0, 256'h1 << wp[0]);
        check("onehot1", hot1, 256'h1 << wp[1]);
        $display("power-up load done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        i_rst = 1'b1;
        board = 2'b10;
        tick(2);
        i_rst = 1'b0;
        powerup();  // host wait after power, scaled down: a full 1 ms would dwarf the run
        for (p = 0; p < 2; p++) begin
            roll();
            cmd(24, `DPSC_OP_WR_WIPER, 2'b00, p[0], v);
            wp[p] = v;
            tick(400);
            check("tap before settle", p ? taps.pos1 : taps.pos0, `DPSC_SLOT_RESET);
            tick(700);
            check("tap after settle", p ? taps.pos1 : taps.pos0, v);
        end
        for (s = 0; s < 4; s++) begin
            roll();
            cmd(24, `DPSC_OP_WR_SLOT, s[1:0], s[0], v);
            sl[s % 2][s] = v;
            wait_nv();
        end
        read_all();
        $display("direct access done");
        cmd(16, `DPSC_OP_SLOT_TO_WP, 2'b01, 1'b1, 8'h00);
        wp[1] = sl[1][1];
        cmd(16, `DPSC_OP_WP_TO_SLOT, 2'b10, 1'b0, 8'h00);
        sl[0][2] = wp[0];
        wait_nv();
        read_all();
        cmd(16, `DPSC_OP_G_SLOT_TO_WP, 2'b11, 1'b0, 8'h00);
        for (p = 0; p < 2; p++) wp[p] = sl[p][3];
        cmd(16, `DPSC_OP_G_WP_TO_SLOT, 2'b00, 1'b0, 8'h00);
        for (p = 0; p < 2; p++) sl[p][0] = wp[p];
        wait_nv();
        read_all();
        $display("transfers done");
        for (p = 0; p < 2; p++) begin
            roll();
            cmd(24, `DPSC_OP_WR_WIPER, 2'b00, p[0], p ? 8'h02 : 8'hfd);
            cmd(24, `DPSC_OP_INCDEC, 2'b00, p[0], v);
            wp[p] = p ? 8'h02 : 8'hfd;
            for (s = 7; s >= 0; s--) begin
                if (v[s]) wp[p] = (wp[p] == 8'hff) ? 8'hff : wp[p] + 8'h01;
                else wp[p] = (wp[p] == 8'h00) ? 8'h00 : wp[p] - 8'h01;
            end
        end
        read_all();
        $display("step commands done");
        roll();
        board = rnd[9:8];
        raw({`DPSC_DEV_TYPE ^ 4'h3, 2'b00, board}, 24, `DPSC_OP_RD_WIPER, 2'b00, 1'b0, 8'h00);
        check("drive on bad type", seen, 1'b0);
        raw({`DPSC_DEV_TYPE, 2'b00, ~board}, 24, `DPSC_OP_RD_WIPER, 2'b00, 1'b0, 8'h00);
        check("drive on bad board", seen, 1'b0);
        raw({`DPSC_DEV_TYPE, 2'b00, ~board}, 24, `DPSC_OP_WR_WIPER, 2'b00, 1'b0, ~wp[0]);
        cmd(24, `DPSC_OP_RD_WIPER, 2'b00, 1'b0, 8'h00);
        check("drive on match", seen, 1'b1);
        check("wiper kept", rx, wp[0]);
        $display("address filter done");
        cmd(24, `DPSC_OP_WR_WIPER, 2'b00, 1'b0, 8'h3c);
        i_rst = 1'b1;
        tick(2);
        i_rst = 1'b0;
        powerup();
        tally_and_finish();
    end

    initial begin
        tick(90000);
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
